// ===== common/dcmbc_pkg.sv
package dcmbc_pkg;

    // ***************************************************************
    // Timing, at a 10 MHz clock
    // ***************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int STANDBY_TIME_US = 1000; // Coast time before standby
    localparam int STANDBY_CYCLES = STANDBY_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int OFF_TIME_NS = 25000; // Fixed off-time, typical
    localparam int OFF_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
    localparam int FAST_PERCENT = 50; // Fast decay share of off-time
    localparam int FAST_CYCLES = OFF_CYCLES * FAST_PERCENT / 100;
    localparam int DEAD_TIME_NS = 50; // Least crossover dead time
    localparam int DEAD_CYCLES_RAW =
        (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYCLES = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
    localparam int WAKE_TIME_NS = 30000; // Charge pump settle, far side
    localparam int CNT_W = 14;

    // ***************************************************************
    // Bridge output carrier
    // ***************************************************************
    typedef struct packed {
        logic out_a; // Level on bridge_out_a
        logic oe_a_n; // Low while bridge_out_a is driven
        logic out_b;
        logic oe_b_n;
    } dcmbc_bridge_s;

    localparam dcmbc_bridge_s BRIDGE_OFF = '{1'b0, 1'b1, 1'b0, 1'b1};

    // Chopping phases
    typedef enum logic [1:0] {
        PH_DRIVE,
        PH_FAST,
        PH_DEAD,
        PH_SLOW
    } dcmbc_phase_e;

endpackage : dcmbc_pkg

// ===== hw/dcmbc_timer.sv
`timescale 1ns/1ps

// Down counter with load, reports zero as a level
module dcmbc_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [13:0] load_val,
    output logic [13:0] count_q,
    output logic done
);

    // ***************************************************************
    // Counter
    // ***************************************************************
    // Load wins over counting so a restart is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 14'h0000;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != 14'h0000) begin
            count_q <= count_q - 14'h0001;
        end
    end

    assign done = (count_q == 14'h0000);

endmodule : dcmbc_timer

// ===== hw/dcmbc_bridge_ctrl.sv
`timescale 1ns/1ps

// Function
// R1: Inputs 1/0 drive out_a high, out_b low; inputs 0/1 the reverse.
// R2: Forward current trip holds out_a low and chops out_b by decay.
// R3: Reverse current trip chops out_a and holds out_b low.
// R4: Both inputs high drive both outputs low for as long as they stay.
// R5: Both inputs low float both outputs and give standby after 1 ms.
// R6: Standby disables the charge pump and the regulator.
// R7: The controller waits up to 30 us after standby before driving.
// R8: A current trip drops the conducting diagonal and starts off-time.
// R9: The first half of off-time is fast decay, the rest slow decay.
// R10: At the fast to slow change all drivers go off for a dead time.
// R11: No synchronous rectification during the dead time.
// R12: Rectify during decay and stop at zero load current.
// R13: Overcurrent sets a fault latch that disables all outputs.
// R14: The fault latch clears only on leaving standby or on power-up.
// R15: Over-temperature disables outputs until its indication clears.
// R16: Undervoltage lockout keeps all drivers off.
// R17: The standby timer restarts whenever either input goes high.
module dcmbc_bridge_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic dir_input_a,
    input wire logic dir_input_b,
    input wire logic current_trip,
    input wire logic zero_current,
    input wire logic overcurrent_detect,
    input wire logic thermal_shutdown,
    input wire logic undervoltage_lockout,
    output dcmbc_pkg::dcmbc_bridge_s bridge_q,
    output logic sync_rect_q,
    output logic standby_q,
    output logic pump_enable_q,
    output logic overcurrent_fault_q,
    output logic [1:0] phase_q
);

    // ***************************************************************
    // Input decode
    // ***************************************************************
    logic fwd;
    logic rev;
    logic brake;
    logic coast;
    logic outputs_blocked;
    assign fwd = dir_input_a & ~dir_input_b;
    assign rev = ~dir_input_a & dir_input_b;
    assign brake = dir_input_a & dir_input_b;
    assign coast = ~dir_input_a & ~dir_input_b;
    // Protection gate; a fresh short blocks on the edge that latches it
    assign outputs_blocked = overcurrent_detect | overcurrent_fault_q
        | thermal_shutdown | undervoltage_lockout; // [R13] [R15] [R16]

    // ***************************************************************
    // Standby timer
    // ***************************************************************
    logic sb_load;
    logic sb_done;
    logic wake;
    assign sb_load = rst | ~coast; // [R17]
    assign wake = standby_q & ~coast;

    // Reset loads the full coast time, so power-up never drops into standby
    dcmbc_timer u_standby_timer (
        .clk(clk),
        .rst(1'b0),
        .load(sb_load),
        .load_val(14'(dcmbc_pkg::STANDBY_CYCLES)),
        .count_q(),
        .done(sb_done)
    );

    // Standby once the coast has lasted the full timer
    always_ff @(posedge clk) begin
        if (rst) begin
            standby_q <= 1'b0;
        end else if (~coast) begin
            standby_q <= 1'b0;
        end else if (sb_done) begin
            standby_q <= 1'b1; // [R5]
        end
    end

    // Pump and regulator off in standby
    always_ff @(posedge clk) begin
        if (rst) begin
            pump_enable_q <= 1'b1;
        end else begin
            pump_enable_q <= ~(coast & (standby_q | sb_done)); // [R6]
        end
    end

    // ***************************************************************
    // Fault latch
    // ***************************************************************
    // Set wins over the standby exit clear; power-up is rst
    always_ff @(posedge clk) begin
        if (rst) begin
            overcurrent_fault_q <= 1'b0;
        end else if (overcurrent_detect) begin
            overcurrent_fault_q <= 1'b1; // [R13]
        end else if (wake) begin
            overcurrent_fault_q <= 1'b0; // [R14]
        end
    end

    // ***************************************************************
    // Off-time sequencer
    // ***************************************************************
    dcmbc_pkg::dcmbc_phase_e ph_q;
    dcmbc_pkg::dcmbc_phase_e ph_d;
    logic tm_load;
    logic [13:0] tm_val;
    logic tm_done;
    logic driving;
    assign driving = (fwd | rev) & ~outputs_blocked;

    dcmbc_timer u_off_timer (
        .clk(clk),
        .rst(rst),
        .load(tm_load),
        .load_val(tm_val),
        .count_q(),
        .done(tm_done)
    );

    // Next phase; drive, fast and dead each load the timer for the following one
    always_comb begin
        ph_d = ph_q;
        tm_load = 1'b0;
        tm_val = 14'h0000;
        case (ph_q)
            dcmbc_pkg::PH_DRIVE: begin
                if (driving & current_trip) begin
                    ph_d = dcmbc_pkg::PH_FAST; // [R8]
                    tm_load = 1'b1;
                    tm_val = 14'(dcmbc_pkg::FAST_CYCLES - 1); // [R9]
                end
            end
            dcmbc_pkg::PH_FAST: begin
                if (tm_done) begin
                    ph_d = dcmbc_pkg::PH_DEAD; // [R10]
                    tm_load = 1'b1;
                    tm_val = 14'(dcmbc_pkg::DEAD_CYCLES - 1);
                end
            end
            dcmbc_pkg::PH_DEAD: begin
                if (tm_done) begin
                    ph_d = dcmbc_pkg::PH_SLOW;
                    tm_load = 1'b1;
                    // Dead time is carved from the slow part
                    tm_val = 14'(dcmbc_pkg::OFF_CYCLES
                        - dcmbc_pkg::FAST_CYCLES
                        - dcmbc_pkg::DEAD_CYCLES - 1); // [R9]
                end
            end
            dcmbc_pkg::PH_SLOW: begin
                if (tm_done) begin
                    ph_d = dcmbc_pkg::PH_DRIVE;
                end
            end
            default: begin
                ph_d = dcmbc_pkg::PH_DRIVE;
            end
        endcase
        // Leaving drive aborts the off-time
        if (~driving) begin
            ph_d = dcmbc_pkg::PH_DRIVE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= dcmbc_pkg::PH_DRIVE;
        end else begin
            ph_q <= ph_d;
        end
    end

    // ***************************************************************
    // Bridge drive
    // ***************************************************************
    dcmbc_pkg::dcmbc_bridge_s br_d;
    logic rect_d;
    logic chop_hi;

    // Fast decay reverses the bridge; slow decay holds both low
    always_comb begin
        br_d = dcmbc_pkg::BRIDGE_OFF;
        rect_d = 1'b0;
        chop_hi = (ph_d == dcmbc_pkg::PH_FAST);
        if (outputs_blocked) begin
            br_d = dcmbc_pkg::BRIDGE_OFF; // [R13] [R15] [R16]
        end else if (brake) begin
            br_d = '{1'b0, 1'b0, 1'b0, 1'b0}; // [R4]
        end else if (coast) begin
            br_d = dcmbc_pkg::BRIDGE_OFF; // [R5]
        end else if (ph_d == dcmbc_pkg::PH_DEAD) begin
            br_d = dcmbc_pkg::BRIDGE_OFF; // [R10] [R11]
        end else if (ph_d == dcmbc_pkg::PH_DRIVE) begin
            br_d = '{fwd, 1'b0, rev, 1'b0}; // [R1]
        end else if (zero_current) begin
            br_d = dcmbc_pkg::BRIDGE_OFF; // [R12]
        end else if (fwd) begin
            br_d = '{1'b0, 1'b0, chop_hi, 1'b0}; // [R2]
            rect_d = 1'b1; // [R12]
        end else begin
            br_d = '{chop_hi, 1'b0, 1'b0, 1'b0}; // [R3]
            rect_d = 1'b1; // [R12]
        end
    end

    // Registered so no output glitches on decode
    always_ff @(posedge clk) begin
        if (rst) begin
            bridge_q <= dcmbc_pkg::BRIDGE_OFF;
            sync_rect_q <= 1'b0;
            phase_q <= 2'h0;
        end else begin
            bridge_q <= br_d;
            sync_rect_q <= rect_d;
            phase_q <= ph_d;
        end
    end

endmodule : dcmbc_bridge_ctrl

// ===== verification/dcmbc_properties.sv
`timescale 1ns/1ps

// ***
// Port checker for the bridge control
// ***
module dcmbc_chk (
    input logic clk,
    input logic rst,
    input logic dir_input_a,
    input logic dir_input_b,
    input logic current_trip,
    input logic zero_current,
    input logic overcurrent_detect,
    input logic thermal_shutdown,
    input logic undervoltage_lockout,
    input dcmbc_pkg::dcmbc_bridge_s bridge_q,
    input logic sync_rect_q,
    input logic standby_q,
    input logic pump_enable_q,
    input logic overcurrent_fault_q,
    input logic [1:0] phase_q
);
    localparam int N = dcmbc_pkg::STANDBY_CYCLES;
    logic [13:0] low_q;
    wire off_z = bridge_q.oe_a_n & bridge_q.oe_b_n;
    // Calm: nothing blocks the bridge and no off-time runs
    wire calm = !(overcurrent_detect | thermal_shutdown |
        undervoltage_lockout | overcurrent_fault_q | standby_q) &&
        phase_q == 2'h0;
    wire ok = calm && !current_trip;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Both-low run length, saturating so it never wraps
    always_ff @(posedge clk) begin
        if (rst | dir_input_a | dir_input_b)
            low_q <= 14'h0;
        else if (low_q != 14'h3fff)
            low_q <= low_q + 14'h1;
    end

    // Off-time phases: fast half, dead time, slow rest
    sequence s_fast;
        phase_q == 2'h1 ##125 phase_q == 2'h2 && off_z && !sync_rect_q;
    endsequence
    sequence s_slow;
        phase_q == 2'h3 ##124 phase_q == 2'h0;
    endsequence

    AST_FWD: assert property (ok && dir_input_a && !dir_input_b
        |=> bridge_q == 4'h8) else $error("fwd drive");
    AST_REV: assert property (ok && !dir_input_a && dir_input_b
        |=> bridge_q == 4'h2) else $error("rev drive");
    AST_BRAKE: assert property (calm && dir_input_a && dir_input_b
        |=> bridge_q == 4'h0) else $error("brake");
    AST_WAKE: assert property (standby_q && !overcurrent_detect &&
        (dir_input_a | dir_input_b) |=> !overcurrent_fault_q && !standby_q)
        else $error("wake clear");
    AST_COAST: assert property (ok && !dir_input_a && !dir_input_b
        |=> off_z) else $error("coast");
    AST_STBY: assert property ($rose(standby_q) |-> low_q >= N)
        else $error("standby early");
    AST_PUMP: assert property (pump_enable_q == !standby_q)
        else $error("pump");
    AST_FAULT: assert property (overcurrent_detect
        |=> overcurrent_fault_q && off_z) else $error("fault");
    AST_PROT: assert property (
        thermal_shutdown | undervoltage_lockout |=> off_z)
        else $error("protect");
    AST_CHOP: assert property (
        calm && dir_input_a != dir_input_b && current_trip
        |=> s_fast ##1 s_slow) else $error("off-time");
    AST_DEAD: assert property (phase_q == 2'h2
        |-> off_z && !sync_rect_q) else $error("dead time");
    AST_ZERO: assert property (zero_current && phase_q[0]
        |=> !sync_rect_q) else $error("zero current");
endmodule : dcmbc_chk

bind dcmbc_bridge_ctrl dcmbc_chk u_dcmbc_chk (
    .clk(clk),
    .rst(rst),
    .dir_input_a(dir_input_a),
    .dir_input_b(dir_input_b),
    .current_trip(current_trip),
    .zero_current(zero_current),
    .overcurrent_detect(overcurrent_detect),
    .thermal_shutdown(thermal_shutdown),
    .undervoltage_lockout(undervoltage_lockout),
    .bridge_q(bridge_q),
    .sync_rect_q(sync_rect_q),
    .standby_q(standby_q),
    .pump_enable_q(pump_enable_q),
    .overcurrent_fault_q(overcurrent_fault_q),
    .phase_q(phase_q)
);

// ===== verification/dcmbc_ctl_model.sv
`timescale 1ns/1ps

// ***
// Controller model on the direction inputs
// ***
module dcmbc_ctl_model (
    input logic clk,
    input logic standby_q,
    input logic [1:0] req,
    output logic dir_input_a,
    output logic dir_input_b
);
    localparam int WAKE = dcmbc_pkg::WAKE_TIME_NS / dcmbc_pkg::CLK_PERIOD_NS;
    int wait_q = 0;
    logic sb_q = 1'b0;

    // Pump settle wait after wake; falling edge keeps pins off sampling
    always @(negedge clk) begin
        sb_q <= standby_q;
        if (sb_q && !standby_q)
            wait_q <= WAKE;
        else if (wait_q != 0)
            wait_q <= wait_q - 1;
    end
    // Pins follow the request; brake is held for as long as asked
    assign {dir_input_a, dir_input_b} = (wait_q != 0) ? 2'h0 : req;
endmodule : dcmbc_ctl_model

// ===== verification/testbench.sv
`timescale 1ns/1ps

// ***
// Bridge control testbench
// ***
module testbench;
    localparam int N = dcmbc_pkg::STANDBY_CYCLES;
    localparam int OFF = dcmbc_pkg::OFF_CYCLES;
    localparam int FST = dcmbc_pkg::FAST_CYCLES;
    localparam int DED = dcmbc_pkg::DEAD_CYCLES;
    typedef struct {int t; logic [7:0] m; logic [7:0] v;} dcmbc_note_s;
    dcmbc_note_s q[$];
    logic clk = 1'b0, rst = 1'b1, trip = 1'b0, zc = 1'b0, oc = 1'b0;
    logic [1:0] req = 2'h0, prot = 2'h0, ph;
    logic a, b, rect, sb, pump, flt;
    dcmbc_pkg::dcmbc_bridge_s br;
    int seed = 86131, cyc = 0, n_errors = 0, compares = 0;
    wire [7:0] st = {br, rect, sb, pump, flt};

    always #50 clk = ~clk;

    dcmbc_bridge_ctrl u_dcmbc_bridge_ctrl (.clk(clk), .rst(rst),
        .dir_input_a(a), .dir_input_b(b), .current_trip(trip),
        .zero_current(zc), .overcurrent_detect(oc),
        .thermal_shutdown(prot[0]), .undervoltage_lockout(prot[1]),
        .bridge_q(br), .sync_rect_q(rect), .standby_q(sb),
        .pump_enable_q(pump), .overcurrent_fault_q(flt), .phase_q(ph));
    dcmbc_ctl_model u_dcmbc_ctl_model (.clk(clk), .standby_q(sb),
        .req(req), .dir_input_a(a), .dir_input_b(b));

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic exp(input int d, input logic [7:0] m, v);
        q.push_back('{cyc + d, m, v});
    endtask : exp
    task automatic cmp(input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("Error status exp %h got %h", e, g);
        end
    endtask : cmp
    task automatic conclude();
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Oldest note is compared once its cycle has settled
    always @(negedge clk) begin
        while (q.size() != 0 && q[0].t <= cyc) begin
            cmp(q[0].v, st & q[0].m);
            void'(q.pop_front());
        end
    end

    // Cycle count; a hang is cut short as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 40000) begin
            n_errors++;
            conclude();
        end
    end

    // One off-time from drive; zero current floats every decay phase
    task automatic chop(input logic [1:0] d, input logic z);
        logic [7:0] dr, fs;
        dr = d[1] ? 8'h82 : 8'h22;
        fs = d[1] ? 8'h2a : 8'h8a;
        req = d;
        exp(1, 8'hff, dr);
        tick(2);
        trip = 1'b1;
        zc = z;
        for (int k = 1; k <= OFF; k++) begin
            if (z) exp(k, 8'h5f, 8'h52);
            else if (k <= FST) exp(k, 8'hff, fs);
            else if (k <= FST + DED) exp(k, 8'h5f, 8'h52);
            else exp(k, 8'hff, 8'h0a);
        end
        exp(OFF + 1, 8'hff, dr);
        tick(1);
        trip = 1'b0;
        tick(OFF + 2);
        zc = 1'b0;
    endtask : chop

    // Main sequence
    initial begin
        tick(20);
        rst = 1'b0;
        repeat (60) begin
            req = 2'($random(seed));
            exp(1, (req == 2'h0) ? 8'h5f : 8'hff,
                (req == 2'h0) ? 8'h52 :
                {req == 2'h2, 1'b0, req == 2'h1, 1'b0, 4'h2});
            tick(1);
        end
        chop(2'h2, 1'b0);
        chop(2'h1, 1'b0);
        chop(2'h2, 1'b1);
        for (int i = 0; i < 2; i++) begin
            prot[i] = 1'b1;
            for (int k = 1; k <= 3; k++)
                exp(k, 8'h5f, 8'h52);
            tick(3);
            prot[i] = 1'b0;
            exp(1, 8'hff, 8'h82);
            tick(2);
        end
        oc = 1'b1;
        exp(1, 8'h5f, 8'h53);
        tick(1);
        oc = 1'b0;
        exp(5, 8'h5f, 8'h53);
        req = 2'h0;
        tick(N - 10);
        req = 2'h2;
        tick(1);
        req = 2'h0;
        exp(12, 8'h07, 8'h03);
        exp(N, 8'h07, 8'h03);
        exp(N + 1, 8'h07, 8'h05);
        tick(N + 5);
        req = 2'h2;
        exp(2, 8'h07, 8'h02);
        exp(340, 8'hff, 8'h82);
        tick(345);
        conclude();
    end
endmodule : testbench
